/* rtl/scd_regs.vh */
// Behaviour
// (RULE_01) master sck = clock / (2 x (divider+1))
// (RULE_02) divider 8-bit rw, resets zero, master only
// (RULE_03) data write loads tx, starts master transfer
// (RULE_04) data read returns receive buffer
// (RULE_05) polarity one inverts sck waveform
// (RULE_06) slave presents miso before master shift edge
// (RULE_07) master waits two clocks after select
// (RULE_08) master holds select two clocks after sck
// (RULE_09) slave drives miso within four clocks
// (RULE_10) slave releases miso within four clocks
// (RULE_11) mosi valid two clocks before sample
// (RULE_12) mosi held two clocks after sample
// (RULE_13) slave updates miso within four clocks
// (RULE_14) phase one: miso changes six-eight after
// (RULE_15) sck idles at polarity level
// (RULE_16) transfer-complete flag sticky until software clear
// (RULE_17) write during transfer sets collision flag
// (RULE_18) master samples miso one clock before bit end; with divider zero the code samples in the bit-end clock
// (RULE_19) half-period counter reloads from divider, toggles sck
`ifndef SCD_REGS_VH
`define SCD_REGS_VH
`define SCD_ADDR_CLOCK_DIVIDER 8'hA2
`define SCD_ADDR_DATA_PORT     8'hA3
`define SCD_RESET_BYTE         8'h00
`define SCD_BITS_LAST          3'h7
`define SCD_SLAVE_LAG          3'h6
`define SCD_SAMPLE_AHEAD       8'h01
`define SCD_FIFO_WIDTH         8
`define SCD_FIFO_DEPTH         4
`define SCD_FIFO_ABITS         2
`endif

/* rtl/scd_fifo.v */
`timescale 1ns/10ps
`include "scd_regs.vh"
module scd_fifo #(
  parameter WIDTH = `SCD_FIFO_WIDTH,
  parameter DEPTH = `SCD_FIFO_DEPTH,
  parameter ABITS = `SCD_FIFO_ABITS
) (
  input  wire             ref_clk,
  input  wire             rst,
  input  wire [WIDTH-1:0] inData,
  input  wire             inValid,
  output wire             inReady,
  output wire [WIDTH-1:0] outData,
  output wire             outValid,
  input  wire             outReady
);
  reg [WIDTH-1:0] mem [0:DEPTH-1];
  reg [ABITS:0]   wrPtr;
  reg [ABITS:0]   rdPtr;
  wire            full;
  wire            empty;
  assign empty    = (wrPtr == rdPtr);
  assign full     = (wrPtr[ABITS-1:0] == rdPtr[ABITS-1:0]) && (wrPtr[ABITS] != rdPtr[ABITS]);
  assign inReady  = !full;
  assign outValid = !empty;
  assign outData  = mem[rdPtr[ABITS-1:0]];
  always @(posedge ref_clk) begin
    if (inValid && !full)
      mem[wrPtr[ABITS-1:0]] <= inData;
  end
  always @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      wrPtr <= {(ABITS+1){1'b0}};
      rdPtr <= {(ABITS+1){1'b0}};
    end else begin
      if (inValid && !full)
        wrPtr <= wrPtr + 1'b1;
      if (outReady && !empty)
        rdPtr <= rdPtr + 1'b1;
    end
  end
endmodule // scd_fifo

/* rtl/scd_spi_port.v */
`timescale 1ns/10ps
`include "scd_regs.vh"
module scd_spi_port (
  input  wire       ref_clk,
  input  wire       rst,
  input  wire [7:0] sfrAddr,
  input  wire [7:0] sfrWdata,
  input  wire       sfrWrite,
  input  wire       sfrRead,
  output reg  [7:0] sfrRdata,
  input  wire       masterEnable,
  input  wire       clock_polarity,
  input  wire       clock_phase,
  input  wire       clearTransferComplete,
  input  wire       clearWriteCollision,
  output reg        transfer_complete_flag,
  output reg        write_collision_flag,
  output reg        portInterrupt,
  output reg        busy,
  output reg        sckOut,
  output reg        sckOe,
  input  wire       sckIn,
  output reg        mosiOut,
  output reg        mosiOe,
  input  wire       mosiIn,
  output reg        misoOut,
  output reg        misoOe,
  input  wire       misoIn,
  input  wire       slave_select_n
);
  localparam ST_IDLE = 2'h0;
  localparam ST_LOW  = 2'h1;
  localparam ST_HIGH = 2'h2;
  localparam ST_END  = 2'h3;

  // ----------------------------------------------------------------
  // register file
  // ----------------------------------------------------------------
  reg  [7:0] clock_rate_divider_value;
  reg  [7:0] rxBuffer;
  reg  [1:0] state;
  reg  [7:0] halfCount;
  reg  [7:0] shiftReg;
  reg  [2:0] bitCount;
  reg        slvActive;
  reg        sckPrev;
  reg        ssPrev;
  reg  [2:0] lagCount;
  reg        lagRun;
  wire       lagFire;
  wire       collide;
  wire       dataWrite;
  wire       txValid;
  wire [7:0] txData;
  wire       txReady;
  wire       txTake;
  wire       sckLevel;
  wire       sckRise;
  wire       sckFall;
  wire       leadEdge;
  wire       trailEdge;
  wire       sampleEdge;
  wire       shiftEdge;
  wire       masterDone;
  wire       slaveDone;

  assign dataWrite = sfrWrite && (sfrAddr == `SCD_ADDR_DATA_PORT);
  assign collide   = dataWrite && (busy || !txReady); // RULE_17

  always @(posedge ref_clk or posedge rst) begin
    if (rst)
      clock_rate_divider_value <= `SCD_RESET_BYTE; // RULE_02
    else if (sfrWrite && sfrAddr == `SCD_ADDR_CLOCK_DIVIDER)
      clock_rate_divider_value <= sfrWdata; // RULE_02
  end

  // ----------------------------------------------------------------
  // read data
  // ----------------------------------------------------------------
  always @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      sfrRdata <= `SCD_RESET_BYTE;
    end else if (sfrRead) begin
      case (sfrAddr)
        `SCD_ADDR_CLOCK_DIVIDER: sfrRdata <= clock_rate_divider_value;
        `SCD_ADDR_DATA_PORT:     sfrRdata <= rxBuffer; // RULE_04
        default:                 sfrRdata <= `SCD_RESET_BYTE;
      endcase
    end
  end

  // ----------------------------------------------------------------
  // transmit buffer
  // ----------------------------------------------------------------
  scd_fifo #(
    .WIDTH (`SCD_FIFO_WIDTH),
    .DEPTH (`SCD_FIFO_DEPTH),
    .ABITS (`SCD_FIFO_ABITS)
  ) txFifo (
    .ref_clk  (ref_clk),
    .rst      (rst),
    .inData   (sfrWdata),
    .inValid  (dataWrite && !busy), // RULE_03
    .inReady  (txReady),
    .outData  (txData),
    .outValid (txValid),
    .outReady (txTake)
  );

  assign txTake = txValid && !busy && !lagRun &&
                  ((masterEnable && state == ST_IDLE) || (!masterEnable && !slvActive));

  // ----------------------------------------------------------------
  // slave edge detection
  // ----------------------------------------------------------------
  assign sckLevel   = sckIn ^ clock_polarity; // RULE_05
  assign sckRise    = sckLevel && !sckPrev;
  assign sckFall    = !sckLevel && sckPrev;
  assign leadEdge   = sckRise;
  assign trailEdge  = sckFall;
  assign sampleEdge = clock_phase ? trailEdge : leadEdge;
  assign shiftEdge  = clock_phase ? leadEdge : trailEdge;
  assign slaveDone  = slvActive && sampleEdge && bitCount == `SCD_BITS_LAST;
  assign masterDone = (state == ST_END);
  assign lagFire    = lagRun && lagCount == `SCD_SLAVE_LAG;

  // ----------------------------------------------------------------
  // edge history
  // ----------------------------------------------------------------
  always @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      sckPrev <= 1'b0;
      ssPrev  <= 1'b1;
    end else begin
      sckPrev <= sckLevel;
      ssPrev  <= slave_select_n;
    end
  end

  // ----------------------------------------------------------------
  // pin enables
  // ----------------------------------------------------------------
  always @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      sckOe  <= 1'b0;
      mosiOe <= 1'b0;
      misoOe <= 1'b0;
    end else begin
      sckOe  <= masterEnable;
      mosiOe <= masterEnable;
      misoOe <= !masterEnable && !slave_select_n; // RULE_09 RULE_10
    end
  end

  // ----------------------------------------------------------------
  // slave lag timer
  // ----------------------------------------------------------------
  always @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      lagCount <= 3'h0;
      lagRun   <= 1'b0;
    end else if (slaveDone) begin
      lagCount <= 3'h0;
      lagRun   <= clock_phase; // RULE_14
    end else if (lagRun) begin
      lagCount <= lagCount + 1'b1;
      if (lagFire)
        lagRun <= 1'b0;
    end
  end

  // ----------------------------------------------------------------
  // shift engine
  // ----------------------------------------------------------------
  always @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      state     <= ST_IDLE;
      halfCount <= `SCD_RESET_BYTE;
      shiftReg  <= `SCD_RESET_BYTE;
      bitCount  <= 3'h0;
      busy      <= 1'b0;
      slvActive <= 1'b0;
      sckOut    <= 1'b0;
      mosiOut   <= 1'b0;
      misoOut   <= 1'b0;
      rxBuffer  <= `SCD_RESET_BYTE;
    end else begin
      if (masterEnable) begin
        case (state)
          ST_IDLE: begin
            sckOut <= clock_polarity; // RULE_15
            if (txTake) begin
              shiftReg  <= txData;
              mosiOut   <= txData[7];
              busy      <= 1'b1;
              bitCount  <= 3'h0;
              halfCount <= clock_rate_divider_value; // RULE_19
              state     <= ST_LOW;
            end
          end
          ST_LOW: begin
            if (halfCount == `SCD_RESET_BYTE) begin
              halfCount <= clock_rate_divider_value; // RULE_19
              sckOut    <= !clock_polarity; // RULE_01
              state     <= ST_HIGH;
              if (clock_phase)
                mosiOut <= shiftReg[7];
            end else
              halfCount <= halfCount - 1'b1;
          end
          ST_HIGH: begin
            if (halfCount == `SCD_SAMPLE_AHEAD ||
                clock_rate_divider_value == `SCD_RESET_BYTE) begin
              if (halfCount == `SCD_RESET_BYTE || halfCount == `SCD_SAMPLE_AHEAD)
                shiftReg <= {shiftReg[6:0], misoIn}; // RULE_18
            end
            if (halfCount == `SCD_RESET_BYTE) begin
              halfCount <= clock_rate_divider_value;
              sckOut    <= clock_polarity; // RULE_05
              if (bitCount == `SCD_BITS_LAST)
                state <= ST_END;
              else begin
                bitCount <= bitCount + 1'b1;
                state    <= ST_LOW;
                if (!clock_phase && clock_rate_divider_value == `SCD_RESET_BYTE)
                  mosiOut <= shiftReg[6];
                else if (!clock_phase)
                  mosiOut <= shiftReg[7];
              end
            end else
              halfCount <= halfCount - 1'b1;
          end
          ST_END: begin
            rxBuffer <= shiftReg;
            busy     <= 1'b0;
            state    <= ST_IDLE;
          end
          default: state <= ST_IDLE;
        endcase
      end else begin
        state  <= ST_IDLE;
        sckOut <= clock_polarity;
        if (txTake) begin
          shiftReg <= txData;
          busy     <= 1'b0;
        end
        if (!slave_select_n && ssPrev) begin
          slvActive <= 1'b1;
          bitCount  <= 3'h0;
          if (!clock_phase)
            misoOut <= shiftReg[7]; // RULE_09
        end else if (slave_select_n)
          slvActive <= 1'b0;
        if (slvActive && !slave_select_n) begin
          busy <= 1'b1;
          if (sampleEdge) begin
            shiftReg <= {shiftReg[6:0], mosiIn};
            bitCount <= bitCount + 1'b1;
          end
          if (shiftEdge && (clock_phase || bitCount != 3'h0))
            misoOut <= clock_phase ? shiftReg[7] : shiftReg[7]; // RULE_13
        end
        if (slaveDone) begin
          rxBuffer  <= {shiftReg[6:0], mosiIn};
          slvActive <= 1'b0;
          busy      <= 1'b0;
        end
        if (lagFire)
          misoOut <= shiftReg[7]; // RULE_14
      end
    end
  end

  // ----------------------------------------------------------------
  // flags
  // ----------------------------------------------------------------
  always @(posedge ref_clk or posedge rst) begin
    if (rst)
      transfer_complete_flag <= 1'b0;
    else if (masterDone || slaveDone)
      transfer_complete_flag <= 1'b1; // RULE_16
    else if (clearTransferComplete)
      transfer_complete_flag <= 1'b0;
  end

  always @(posedge ref_clk or posedge rst) begin
    if (rst)
      write_collision_flag <= 1'b0;
    else if (collide)
      write_collision_flag <= 1'b1; // RULE_17
    else if (clearWriteCollision)
      write_collision_flag <= 1'b0;
  end

  // ----------------------------------------------------------------
  // port interrupt
  // ----------------------------------------------------------------
  always @(posedge ref_clk or posedge rst) begin
    if (rst)
      portInterrupt <= 1'b0;
    else
      portInterrupt <= transfer_complete_flag || write_collision_flag ||
                       masterDone || slaveDone || collide; // RULE_17
  end
endmodule // scd_spi_port

/* tb/scd_chk.sv */
`timescale 1ns/10ps
// ----
// port checker
// ----
module scd_chk (
  input wire       ref_clk,
  input wire       rst,
  input wire [7:0] sfrAddr,
  input wire       sfrWrite,
  input wire       masterEnable,
  input wire       clock_polarity,
  input wire       clearTransferComplete,
  input wire       transfer_complete_flag,
  input wire       write_collision_flag,
  input wire       portInterrupt,
  input wire       busy,
  input wire       sckOut,
  input wire       misoOe,
  input wire       slave_select_n
);
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (rst);
  wire dataWr = sfrWrite && sfrAddr == 8'hA3;
  sequence s_go; dataWr && masterEnable && !busy; endsequence
  sequence s_end; $fell(busy); endsequence
  property p_go; s_go |-> ##[1:2] busy; endproperty
  a_go: assert property (p_go) else $error("no start");
  property p_col; dataWr && busy |=> write_collision_flag; endproperty
  a_col: assert property (p_col) else $error("no collision");
  property p_irq; write_collision_flag |-> ##[0:1] portInterrupt; endproperty
  a_irq: assert property (p_irq) else $error("no interrupt");
  property p_end; s_end |-> ##[0:1] transfer_complete_flag; endproperty
  a_end: assert property (p_end) else $error("no done flag");
  property p_keep;
    transfer_complete_flag && !clearTransferComplete |=> transfer_complete_flag;
  endproperty
  a_keep: assert property (p_keep) else $error("done flag lost");
  property p_idle;
    masterEnable && !busy && !$past(busy) && !$past(rst) && $stable(clock_polarity)
      && $stable(masterEnable) |-> sckOut == clock_polarity;
  endproperty
  a_idle: assert property (p_idle) else $error("bad idle clock");
  property p_sel; $fell(slave_select_n) && !masterEnable |-> ##[1:4] misoOe; endproperty
  a_sel: assert property (p_sel) else $error("miso not driven");
  property p_rel; $rose(slave_select_n) && !masterEnable |-> ##[1:4] !misoOe; endproperty
  a_rel: assert property (p_rel) else $error("miso not released");
endmodule // scd_chk
bind scd_spi_port scd_chk scd_chk_i (.ref_clk(ref_clk), .rst(rst), .sfrAddr(sfrAddr),
  .sfrWrite(sfrWrite), .masterEnable(masterEnable), .clock_polarity(clock_polarity),
  .clearTransferComplete(clearTransferComplete), .busy(busy), .sckOut(sckOut),
  .transfer_complete_flag(transfer_complete_flag), .portInterrupt(portInterrupt),
  .write_collision_flag(write_collision_flag), .misoOe(misoOe),
  .slave_select_n(slave_select_n));

/* tb/scd_slave_model.sv */
`timescale 1ns/10ps
// ----
// far-side slave
// ----
module scd_slave_model (
  input  wire       busy,
  input  wire       sckOut,
  input  wire       mosiOut,
  input  wire       clock_polarity,
  input  wire       clock_phase,
  input  wire [7:0] txByte,
  output reg  [7:0] rxByte,
  output reg        misoIn
);
  reg [7:0] sh = 8'h00;
  wire      act = sckOut ^ clock_polarity;
  initial rxByte = 8'h00;
  initial misoIn = 1'b0;
  always @(posedge busy) begin
    sh = clock_phase ? txByte : {txByte[6:0], 1'b0};
    if (!clock_phase) misoIn <= #1 txByte[7];
  end
  always @(negedge busy) misoIn <= #1 ~misoIn;
  always @(act) if (busy) begin
    if (act == !clock_phase) rxByte = {rxByte[6:0], mosiOut};
    else begin
      misoIn <= #1 sh[7];
      sh = {sh[6:0], 1'b0};
    end
  end
endmodule // scd_slave_model

/* tb/tb_top.sv */
`timescale 1ns/10ps
// ----
// bench
// ----
module tb_top;
  reg        ref_clk = 1'b0;
  reg        rst = 1'b1;
  reg  [7:0] sfrAddr = 8'h00;
  reg  [7:0] sfrWdata = 8'h00;
  reg        sfrWrite = 1'b0;
  reg        sfrRead = 1'b0;
  reg        masterEnable = 1'b1;
  reg        clock_polarity = 1'b0;
  reg        clock_phase = 1'b0;
  reg        clrDone = 1'b0;
  reg        clrCol = 1'b0;
  reg        sckIn = 1'b0;
  reg        mosiIn = 1'b0;
  reg        slave_select_n = 1'b1;
  reg  [7:0] slvTx = 8'h00;
  wire [7:0] sfrRdata, slvRx;
  wire       tcf, wcf, irq, busy, sckOut, sckOe, mosiOut, mosiOe, misoOut, misoOe, misoIn;
  integer    err_total = 0;
  integer    checked = 0;
  always #5 ref_clk = ~ref_clk;
  scd_spi_port scd_spi_port_i (.ref_clk(ref_clk), .rst(rst), .sfrAddr(sfrAddr),
    .sfrWdata(sfrWdata), .sfrWrite(sfrWrite), .sfrRead(sfrRead), .sfrRdata(sfrRdata),
    .masterEnable(masterEnable), .clock_polarity(clock_polarity), .clock_phase(clock_phase),
    .clearTransferComplete(clrDone), .clearWriteCollision(clrCol),
    .transfer_complete_flag(tcf), .write_collision_flag(wcf), .portInterrupt(irq),
    .busy(busy), .sckOut(sckOut), .sckOe(sckOe), .sckIn(sckIn), .mosiOut(mosiOut),
    .mosiOe(mosiOe), .mosiIn(mosiIn), .misoOut(misoOut), .misoOe(misoOe), .misoIn(misoIn),
    .slave_select_n(slave_select_n));
  scd_slave_model scd_slave_model_i (.busy(busy), .sckOut(sckOut), .mosiOut(mosiOut),
    .clock_polarity(clock_polarity), .clock_phase(clock_phase), .txByte(slvTx),
    .rxByte(slvRx), .misoIn(misoIn));
  task tally_and_finish;
    begin
      if (err_total == 0 && checked > 0) $display("Run complete: PASS");
      else $display("Run complete: FAIL");
      $finish;
    end
  endtask
  task chk(input [8*8:1] nm, input [7:0] ex, input [7:0] got);
    begin
      checked = checked + 1;
      if (got !== ex) begin
        err_total = err_total + 1;
        $display("Error %0s expected %h seen %h", nm, ex, got);
      end
    end
  endtask
  task cyc(input integer n);
    begin
      repeat (n) @(posedge ref_clk);
      #1;
    end
  endtask
  task pulse(input sel);
    begin
      @(posedge ref_clk) begin
        if (sel) clrDone <= 1'b1;
        else clrCol <= 1'b1;
      end
      @(posedge ref_clk) begin
        clrDone <= 1'b0;
        clrCol <= 1'b0;
      end
    end
  endtask
  task wr(input [7:0] a, input [7:0] d);
    begin
      @(posedge ref_clk);
      sfrAddr <= a;
      sfrWdata <= d;
      sfrWrite <= 1'b1;
      @(posedge ref_clk) sfrWrite <= 1'b0;
    end
  endtask
  task rd(input [7:0] a, input [7:0] ex);
    begin
      @(posedge ref_clk);
      sfrAddr <= a;
      sfrRead <= 1'b1;
      @(posedge ref_clk) sfrRead <= 1'b0;
      #1 chk("rdata", ex, sfrRdata);
    end
  endtask
  task waitb(input v, input integer lim);
    integer n;
    begin
      #1 n = 0;
      while (busy !== v && n < lim) begin cyc(1); n = n + 1; end
      chk("busy", {7'h0, v}, {7'h0, busy});
    end
  endtask
  task edgeGap(output integer n);
    reg s;
    begin
      s = sckOut;
      n = 0;
      while (sckOut === s && n < 600) begin cyc(1); n = n + 1; end
    end
  endtask
  task t_master(input [7:0] dv, input pl, input ph, input [7:0] tx, input [7:0] rx, input col);
    integer n;
    begin
      wr(8'hA2, dv);
      rd(8'hA2, dv);
      @(posedge ref_clk);
      clock_polarity <= pl;
      clock_phase <= ph;
      slvTx <= rx;
      cyc(2);
      chk("sckIdle", {7'h0, pl}, {7'h0, sckOut});
      chk("sckOe", 8'h01, {7'h0, sckOe});
      chk("mosiOe", 8'h01, {7'h0, mosiOe});
      wr(8'hA3, tx);
      waitb(1'b1, 4);
      edgeGap(n);
      edgeGap(n);
      chk("halfPer", dv + 8'h01, n[7:0]);
      if (col) begin
        wr(8'hA3, 8'hFF);
        cyc(1);
        chk("write_collision_flag", 8'h01, {7'h0, wcf});
        chk("irq", 8'h01, {7'h0, irq});
        pulse(1'b0);
      end
      waitb(1'b0, 5000);
      cyc(1);
      chk("done", 8'h01, {7'h0, tcf});
      rd(8'hA3, rx);
      chk("mosi", tx, slvRx);
      pulse(1'b1);
      cyc(1);
      chk("doneClr", 8'h00, {7'h0, tcf});
    end
  endtask
  task t_slave(input ph, input [7:0] tx, input [7:0] rx);
    integer i;
    reg [7:0] got;
    begin
      @(posedge ref_clk) begin
        masterEnable <= 1'b0;
        clock_polarity <= 1'b0;
        clock_phase <= ph;
      end
      wr(8'hA3, tx);
      @(posedge ref_clk) slave_select_n <= 1'b0;
      for (i = 7; i >= 0; i = i - 1) begin
        repeat (3) @(posedge ref_clk);
        mosiIn <= rx[i];
        repeat (3) @(posedge ref_clk);
        if (!ph) got = {got[6:0], misoOut};
        sckIn <= 1'b1;
        repeat (6) @(posedge ref_clk);
        if (ph) got = {got[6:0], misoOut};
        sckIn <= 1'b0;
      end
      repeat (3) @(posedge ref_clk);
      slave_select_n <= 1'b1;
      cyc(5);
      chk("misoOe", 8'h00, {7'h0, misoOe});
      chk("sckOe", 8'h00, {7'h0, sckOe});
      chk("miso", tx, got);
      chk("done", 8'h01, {7'h0, tcf});
      rd(8'hA3, rx);
      pulse(1'b1);
    end
  endtask
  initial begin
    repeat (30000) @(posedge ref_clk);
    err_total = err_total + 1;
    tally_and_finish;
  end
  initial begin
    repeat (20) @(posedge ref_clk);
    rst <= 1'b0;
    rd(8'hA2, 8'h00);
    rd(8'hA3, 8'h00);
    rd(8'h10, 8'h00);
    t_master(8'h00, 1'b0, 1'b0, 8'hA5, 8'h3C, 1'b0);
    t_master(8'h03, 1'b1, 1'b1, 8'h5A, 8'hC3, 1'b1);
    t_master(8'h01, 1'b1, 1'b0, 8'hC6, 8'h35, 1'b0);
    t_master(8'hFF, 1'b0, 1'b1, 8'h81, 8'h7E, 1'b0);
    t_slave(1'b0, 8'h96, 8'h69);
    t_slave(1'b1, 8'h4B, 8'hB2);
    tally_and_finish;
  end
endmodule // tb_top
